// ---- ipas_host_model.sv ----
// Host controller model: writes 16-bit command words into the pin select block.
// Assumes the bench calls its tasks and that inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none

module ipas_host_model (
  input  wire logic           mclk,
  output logic                cmd_valid,
  output ipas_pkg::ipas_cmd_t cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // A following send keeps the strobe high, so back-to-back words never glitch
  task automatic send(input logic m, input logic [3:0] a, input logic [7:0] s);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd.msb   = m;
    cmd.addr  = a;
    cmd.rsvd  = 3'h0;
    cmd.sel   = s;
  endtask

  // Breaks the reserved-bit duty on purpose, to probe that the block still takes the word
  task automatic send_rsvd(input logic [3:0] a, input logic [2:0] r, input logic [7:0] s);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd.msb   = 1'b0;
    cmd.addr  = a;
    cmd.rsvd  = r;
    cmd.sel   = s;
  endtask

  // Released lines show the inverse so a stale word never passes for data
  task automatic idle();
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd       = ~cmd;
  endtask
endmodule // ipas_host_model
`default_nettype wire

// ---- ipas_params.svh ----
// Constants for the analog pin function select block: command field codes and reset values.
// Assumes it is included by bare name wherever the block's codes are needed.
`ifndef IPAS_PARAMS_SVH
`define IPAS_PARAMS_SVH

// =============================================================
// Command word fields
`define IPAS_CMD_WIDTH       16
`define IPAS_MSB_WRITE       1'b0
`define IPAS_ADDR_AIN        4'h4
`define IPAS_ADDR_AOUT       4'h5
`define IPAS_RSVD_VALUE      3'h0

// =============================================================
// Reset values and pin count
`define IPAS_SEL_RESET       8'h00
`define IPAS_PIN_COUNT       8

`endif

// ---- ipas_pin_select.sv ----
// Analog-input and analog-output pin select registers, written by 16-bit command words.
// Assumes the serial front end delivers each whole word as a one-cycle strobe on mclk,
// and that the lock level comes from the general control register on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "ipas_params.svh"

// Notes on behaviour
// - Word with bit 15 zero and address 0b0100 writes the analog-input select register.
// - Word with bit 15 zero and address 0b0101 writes the analog-output select register.
// - Analog-input bit n controls pin n; all bits reset to zero.
// - Analog-input bit at one makes pin n a converter input channel.
// - Analog-output bit n controls pin n; all bits reset to zero.
// - Analog-output bit at one drives pin n from its output converter.
// - Pin with both bits zero is not claimed; other registers decide it.
// - While lock is high, writes to either select register are ignored.
module ipas_pin_select #(
  parameter int unsigned           PINS = `IPAS_PIN_COUNT
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                cmd_valid,
  input  wire ipas_pkg::ipas_cmd_t cmd,
  input  wire logic                cfg_lock,
  output ipas_pkg::ipas_pin_cfg_t  pin_cfg,
  output logic      [PINS-1:0]     analog_in_sel,
  output logic      [PINS-1:0]     analog_out_sel,
  output logic                     write_done,
  output logic                     write_refused
);

  // =============================================================
  // Command decode
  logic            is_write;
  logic            hit_ain;
  logic            hit_aout;
  logic            load_ain;
  logic            load_aout;
  logic [PINS-1:0] next_ain;
  logic [PINS-1:0] next_aout;

  // Reserved bits are not checked: a host slip there must not lose the pin setting.
  always_comb begin
    is_write = cmd_valid && (cmd.msb == `IPAS_MSB_WRITE);
    hit_ain  = is_write && (cmd.addr == `IPAS_ADDR_AIN);
    hit_aout = is_write && (cmd.addr == `IPAS_ADDR_AOUT);
  end

  // Other addresses fall through with both loads low
  always_comb begin
    load_ain  = hit_ain && !cfg_lock;
    load_aout = hit_aout && !cfg_lock;
  end

  always_comb begin
    next_ain  = load_ain  ? cmd.sel[PINS-1:0] : analog_in_sel;
    next_aout = load_aout ? cmd.sel[PINS-1:0] : analog_out_sel;
  end

  // =============================================================
  // Select registers
  ipas_sel_reg #(
    .W     (PINS),
    .RESET (PINS'(`IPAS_SEL_RESET))
  ) u_ain_reg (
    .mclk  (mclk),
    .rst   (rst),
    .load  (load_ain),
    .d     (cmd.sel[PINS-1:0]),
    .q     (analog_in_sel)
  );

  ipas_sel_reg #(
    .W     (PINS),
    .RESET (PINS'(`IPAS_SEL_RESET))
  ) u_aout_reg (
    .mclk  (mclk),
    .rst   (rst),
    .load  (load_aout),
    .d     (cmd.sel[PINS-1:0]),
    .q     (analog_out_sel)
  );

  // =============================================================
  // Pin claims
  // Registered from the next values so they change on the same edge as the selects.
  // Both bits set on one pin is passed through as is; the pad logic arbitrates.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_cfg.conv_in   <= PINS'(`IPAS_SEL_RESET);
      pin_cfg.dac_drive <= PINS'(`IPAS_SEL_RESET);
      pin_cfg.free      <= ~PINS'(`IPAS_SEL_RESET);
    end else begin
      pin_cfg.conv_in   <= next_ain;
      pin_cfg.dac_drive <= next_aout;
      pin_cfg.free      <= ~(next_ain | next_aout);
    end
  end

  // =============================================================
  // Write status pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_done <= 1'b0;
    end else begin
      write_done <= load_ain || load_aout;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_refused <= 1'b0;
    end else begin
      write_refused <= (hit_ain || hit_aout) && cfg_lock;
    end
  end

  // =============================================================
  // Checks
  sequence ain_cmd_s;
    cmd_valid && !cmd.msb && cmd.addr == 4'h4 && !cfg_lock;
  endsequence

  sequence aout_cmd_s;
    cmd_valid && !cmd.msb && cmd.addr == 4'h5 && !cfg_lock;
  endsequence

  sequence locked_cmd_s;
    cmd_valid && !cmd.msb && (cmd.addr == 4'h4 || cmd.addr == 4'h5) && cfg_lock;
  endsequence

  sequence regs_held_s;
    $stable(analog_in_sel) && $stable(analog_out_sel);
  endsequence

  ain_write_load_a: assert property (
    @(posedge mclk) disable iff (rst)
    ain_cmd_s |=> analog_in_sel == $past(cmd.sel) && $stable(analog_out_sel))
    else $error("Analog-input select did not take the written word");

  aout_write_load_a: assert property (
    @(posedge mclk) disable iff (rst)
    aout_cmd_s |=> analog_out_sel == $past(cmd.sel) && $stable(analog_in_sel))
    else $error("Analog-output select did not take the written word");

  rsvd_ignored_a: assert property (
    @(posedge mclk) disable iff (rst)
    (ain_cmd_s and (cmd.rsvd != 3'h0)) |=> analog_in_sel == $past(cmd.sel))
    else $error("Nonzero reserved bits blocked a write");

  reset_zero_a: assert property (
    @(posedge mclk)
    rst ##1 rst |-> analog_in_sel == 8'h00 && analog_out_sel == 8'h00
                    && pin_cfg.free == 8'hFF)
    else $error("Select registers not zero under reset");

  conv_in_claim_a: assert property (
    @(posedge mclk) disable iff (rst)
    ain_cmd_s |=> pin_cfg.conv_in == $past(cmd.sel))
    else $error("Converter input claim does not follow the write");

  aout_reset_a: assert property (
    @(posedge mclk)
    $fell(rst) |-> analog_out_sel == 8'h00 && pin_cfg.dac_drive == 8'h00)
    else $error("Analog-output select not zero after reset");

  dac_drive_claim_a: assert property (
    @(posedge mclk) disable iff (rst)
    aout_cmd_s |=> pin_cfg.dac_drive == $past(cmd.sel))
    else $error("Output converter claim does not follow the write");

  free_pin_a: assert property (
    @(posedge mclk) disable iff (rst)
    pin_cfg.free == ~(analog_in_sel | analog_out_sel))
    else $error("Unclaimed pin map disagrees with the selects");

  lock_ignore_a: assert property (
    @(posedge mclk) disable iff (rst)
    locked_cmd_s |=> regs_held_s ##0 write_refused)
    else $error("Locked write changed a select register");

  other_addr_a: assert property (
    @(posedge mclk) disable iff (rst)
    (cmd_valid && (cmd.msb || (cmd.addr != 4'h4 && cmd.addr != 4'h5)))
      |=> regs_held_s and !write_done and !write_refused)
    else $error("Foreign command word changed a select register");

  // =============================================================
  // Cause checks
  // Locked words may arrive back to back, so the refusal pulse is tied to its cause
  // rather than to a fixed width.
  refuse_cause_a: assert property (
    @(posedge mclk) disable iff (rst)
    write_refused |-> $past(cmd_valid && !cmd.msb && cfg_lock
                            && (cmd.addr == 4'h4 || cmd.addr == 4'h5)))
    else $error("Refusal pulse without a locked select write");

  done_cause_a: assert property (
    @(posedge mclk) disable iff (rst)
    write_done |-> $past(cmd_valid && !cmd.msb && !cfg_lock
                         && (cmd.addr == 4'h4 || cmd.addr == 4'h5)))
    else $error("Write pulse without an accepted select write");

  pulse_excl_a: assert property (
    @(posedge mclk) disable iff (rst)
    !(write_done && write_refused))
    else $error("Write reported both taken and refused");

  // A select may only move on its own address; this catches a crossed load strobe.
  ain_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable(analog_in_sel)
      |-> $past(cmd_valid && !cmd.msb && !cfg_lock && cmd.addr == 4'h4))
    else $error("Analog-input select moved without its own write");

  aout_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable(analog_out_sel)
      |-> $past(cmd_valid && !cmd.msb && !cfg_lock && cmd.addr == 4'h5))
    else $error("Analog-output select moved without its own write");

  ain_reset_a: assert property (
    @(posedge mclk)
    $fell(rst) |-> analog_in_sel == 8'h00 && pin_cfg.conv_in == 8'h00)
    else $error("Analog-input select not zero after reset");

endmodule // ipas_pin_select

`default_nettype wire

// ---- ipas_pin_select_tb.sv ----
// Self-checking bench for the analog pin select registers.
// Assumes the host model drives command words and the bench drives lock and reset.
`timescale 1ns/10ps
`default_nettype none

module ipas_pin_select_tb;
  logic                    mclk;
  logic                    rst;
  logic                    cfg_lock;
  logic                    cmd_valid;
  ipas_pkg::ipas_cmd_t     cmd;
  ipas_pkg::ipas_pin_cfg_t pin_cfg;
  logic [7:0]              analog_in_sel;
  logic [7:0]              analog_out_sel;
  logic                    write_done;
  logic                    write_refused;
  int                      err_total = 0;
  int                      check_count = 0;
  int                      cyc = 0;

  ipas_host_model i_ipas_host_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd));
  ipas_pin_select #(.PINS(8)) i_ipas_pin_select (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cfg_lock(cfg_lock),
    .pin_cfg(pin_cfg), .analog_in_sel(analog_in_sel), .analog_out_sel(analog_out_sel),
    .write_done(write_done), .write_refused(write_refused));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // =============================================================
  // Checking and access tasks
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic state(input logic [7:0] ei, eo, input logic d, r);
    chk("analog_in_sel", ei, analog_in_sel);
    chk("analog_out_sel", eo, analog_out_sel);
    chk("conv_in", ei, pin_cfg.conv_in);
    chk("dac_drive", eo, pin_cfg.dac_drive);
    chk("free", ~(ei | eo), pin_cfg.free);
    chk("write_done", {7'h00, d}, {7'h00, write_done});
    chk("write_refused", {7'h00, r}, {7'h00, write_refused});
  endtask

  task automatic wr(input logic m, input logic [3:0] a, input logic [7:0] s, input logic lk,
                    input logic [7:0] ei, eo, input logic d, r);
    i_ipas_host_model.send(m, a, s);
    cfg_lock = lk;
    i_ipas_host_model.idle();
    state(ei, eo, d, r);
  endtask

  task automatic test_end(input string t);
    $display("test %s finished", t);
  endtask

  // Ceiling sits far above the roughly 85 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end

  // =============================================================
  // Test sequence
  initial begin
    rst      = 1'b1;
    cfg_lock = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    state(8'h00, 8'h00, 1'b0, 1'b0);
    test_end("reset");
    wr(1'b0, 4'h4, 8'h55, 1'b0, 8'h55, 8'h00, 1'b1, 1'b0);
    wr(1'b0, 4'h5, 8'hA5, 1'b0, 8'h55, 8'hA5, 1'b1, 1'b0);
    test_end("basic");
    for (int n = 0; n < 8; n++) begin
      wr(1'b0, 4'h4, 8'h01 << n, 1'b0, 8'h01 << n,
         (n == 0) ? 8'hA5 : 8'h80 >> (n - 1), 1'b1, 1'b0);
      wr(1'b0, 4'h5, 8'h80 >> n, 1'b0, 8'h01 << n, 8'h80 >> n, 1'b1, 1'b0);
    end
    test_end("pin walk");
    wr(1'b0, 4'h4, 8'hFF, 1'b1, 8'h80, 8'h01, 1'b0, 1'b1);
    wr(1'b0, 4'h5, 8'hFF, 1'b1, 8'h80, 8'h01, 1'b0, 1'b1);
    wr(1'b1, 4'h4, 8'hFF, 1'b0, 8'h80, 8'h01, 1'b0, 1'b0);
    test_end("lock");
    for (int a = 0; a < 16; a++) begin
      if (a != 4 && a != 5) begin
        wr(1'b0, a[3:0], 8'hFF, 1'b0, 8'h80, 8'h01, 1'b0, 1'b0);
      end
    end
    i_ipas_host_model.send_rsvd(4'h4, 3'h7, 8'h18);
    i_ipas_host_model.idle();
    state(8'h18, 8'h01, 1'b1, 1'b0);
    test_end("decode");
    i_ipas_host_model.send(1'b0, 4'h4, 8'h0F);
    i_ipas_host_model.send(1'b0, 4'h5, 8'hF0);
    state(8'h0F, 8'h01, 1'b1, 1'b0);
    i_ipas_host_model.idle();
    state(8'h0F, 8'hF0, 1'b1, 1'b0);
    test_end("back to back");
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    state(8'h00, 8'h00, 1'b0, 1'b0);
    rst = 1'b0;
    wr(1'b0, 4'h4, 8'h3C, 1'b0, 8'h3C, 8'h00, 1'b1, 1'b0);
    test_end("reset again");
    complete_run();
  end
endmodule // ipas_pin_select_tb
`default_nettype wire

// ---- ipas_pkg.sv ----
// Types for the analog pin function select block.
// Assumes ipas_params.svh supplies the widths used here.
`include "ipas_params.svh"

package ipas_pkg;

  // =============================================================
  // Command word as written by the host controller, bit 15 first
  typedef struct packed {
    logic       msb;
    logic [3:0] addr;
    logic [2:0] rsvd;
    logic [7:0] sel;
  } ipas_cmd_t;

  // =============================================================
  // Per-pin function claims handed to the pad and converter logic
  typedef struct packed {
    logic [`IPAS_PIN_COUNT-1:0] conv_in;
    logic [`IPAS_PIN_COUNT-1:0] dac_drive;
    logic [`IPAS_PIN_COUNT-1:0] free;
  } ipas_pin_cfg_t;

endpackage

// ---- ipas_sel_reg.sv ----
// One per-pin select register with load and asynchronous reset.
// Assumes the load strobe and data come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module ipas_sel_reg #(
  parameter int unsigned           W     = 8,
  parameter logic [W-1:0]          RESET = '0
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                load,
  input  wire logic [W-1:0]        d,
  output logic      [W-1:0]        q
);

  // =============================================================
  // Storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= RESET;
    end else if (load) begin
      q <= d;
    end
  end

endmodule // ipas_sel_reg

`default_nettype wire
